// >>> rtl/dmps_pkg.sv
// constants, offsets and types shared by the pll setup controller
package dmps_pkg;

	// reference clock into the pll, in MHz
	localparam logic [6:0]  REF_CLK_MHZ     = 7'h64;

	// controller register offsets (software port)
	localparam logic [4:0]  OFF_CTRL        = 5'h00;
	localparam logic [4:0]  OFF_DDR_CFG     = 5'h04;
	localparam logic [4:0]  OFF_MAIN_CFG    = 5'h08;
	localparam logic [4:0]  OFF_STATUS      = 5'h0C;
	localparam logic [4:0]  OFF_FREQ        = 5'h10;

	// control register bits
	localparam int          CTRL_GO_DDR     = 0;
	localparam int          CTRL_GO_MAIN    = 1;
	localparam int          CTRL_MEM_INIT   = 2;

	// status register bits
	localparam int          STAT_BUSY       = 0;
	localparam int          STAT_DDR_DONE   = 1;
	localparam int          STAT_MAIN_DONE  = 2;
	localparam int          STAT_DIV2_ON    = 3;
	localparam int          STAT_MEM_OPEN   = 4;
	localparam int          STAT_REFUSED    = 5;

	// device register addresses
	localparam logic [31:0] DEV_DDR_PLL_CTL0 = 32'h0262_0330;
	localparam logic [31:0] DEV_PHY_PLL_CTL  = 32'h0232_9018;
	localparam logic [31:0] DEV_SEC_CTL      = 32'h0231_0108;
	localparam logic [31:0] DEV_MAIN_PLL_CTL = 32'h0231_0110;

	// pll word fields: ref divider, multiplier, output divider
	localparam int          PLL_D_LSB       = 0;
	localparam int          PLL_D_W         = 6;
	localparam int          PLL_M_LSB       = 6;
	localparam int          PLL_M_W         = 13;
	localparam int          PLL_OD_LSB      = 19;
	localparam int          PLL_OD_W        = 5;

	// reset values of the memory pll settings (200 MHz, 400 MT/s)
	localparam logic [5:0]  DDR_D_RST       = 6'h00;
	localparam logic [12:0] DDR_M_RST       = 13'h0027;
	localparam logic [4:0]  DDR_OD_RST      = 5'h13;

	// reset values of the main pll settings
	localparam logic [5:0]  MAIN_D_RST      = 6'h00;
	localparam logic [12:0] MAIN_M_RST      = 13'h0013;

	// phy pll control fields and init values
	localparam int          PHY_FRQ_LSB     = 0;
	localparam int          PHY_CPCUR_LSB   = 2;
	localparam logic [1:0]  PHY_FRQ_INIT    = 2'h3;
	localparam logic [3:0]  PHY_CPCUR_INIT  = 4'hF;

	// secondary control output divider field
	localparam int          SEC_OD_LSB      = 19;
	localparam logic [31:0] SEC_OD_MASK     = 32'h0078_0000;
	localparam logic [3:0]  SEC_OD_DIV2     = 4'h1;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_DDR_PLL  = 3'b001,
		ST_PHY_PLL  = 3'b010,
		ST_SEC_RD   = 3'b011,
		ST_SEC_WR   = 3'b100,
		ST_MAIN_PLL = 3'b101
	} dmps_state_type;

endpackage

// >>> rtl/dmps_bus_master.sv
// single-access master on the device register port
`timescale 1ns/1ps
module dmps_bus_master import dmps_pkg::*; (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// request from the sequencer
	input  wire logic        go,
	input  wire logic        go_wr,
	input  wire logic [31:0] go_addr,
	input  wire logic [31:0] go_wdata,
	output logic             done,
	output logic [31:0]      rdata,
	// device register port
	output logic [31:0]      dev_addr,
	output logic [31:0]      dev_wdata,
	output logic             dev_wr,
	output logic             dev_rd,
	input  wire logic [31:0] dev_rdata
);

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
		logic        pend;
		logic        pend_rd;
		logic        done;
		logic [31:0] rdata;
	} dmps_bm_type;

	dmps_bm_type s_r;
	dmps_bm_type s_nxt;

	always_comb begin
		s_nxt         = s_r;
		s_nxt.wr      = go & go_wr;
		s_nxt.rd      = go & ~go_wr;
		s_nxt.pend    = s_r.wr | s_r.rd;
		s_nxt.pend_rd = s_r.rd;
		s_nxt.done    = s_r.pend;
		if (go) begin
			s_nxt.addr  = go_addr;
			s_nxt.wdata = go_wdata;
		end
		// read data stand only in the cycle after the strobe
		if (s_r.pend && s_r.pend_rd) begin
			s_nxt.rdata = dev_rdata;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign dev_addr  = s_r.addr;
	assign dev_wdata = s_r.wdata;
	assign dev_wr    = s_r.wr;
	assign dev_rd    = s_r.rd;
	assign done      = s_r.done;
	assign rdata     = s_r.rdata;

endmodule // dmps_bus_master

// >>> rtl/dmps_freq_calc.sv
// output frequency of the main pll from its settings
`timescale 1ns/1ps
module dmps_freq_calc import dmps_pkg::*; (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// settings
	input  wire logic        valid,
	input  wire logic [5:0]  ref_div,
	input  wire logic [12:0] mult,
	input  wire logic [3:0]  out_div,
	// result in MHz
	output logic [31:0]      freq_mhz
);

	typedef struct packed {
		logic [31:0] freq;
	} dmps_fc_type;

	dmps_fc_type s_r;
	dmps_fc_type s_nxt;
	logic [31:0] num;
	logic [31:0] den;

	always_comb begin
		num = 32'(REF_CLK_MHZ) * (32'(mult) + 32'h1);
		den = (32'(out_div) + 32'h1) * (32'(ref_div) + 32'h1);
		s_nxt = s_r;
		// only meaningful once divide-by-two is on
		s_nxt.freq = valid ? (num / den) : 32'h0;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign freq_mhz = s_r.freq;

endmodule // dmps_freq_calc

// >>> rtl/dmps_ctrl.sv
// memory and main pll setup controller, host side
`timescale 1ns/1ps
module dmps_ctrl import dmps_pkg::*; (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// software register port
	input  wire logic [4:0]  sw_addr,
	input  wire logic [31:0] sw_wdata,
	input  wire logic        sw_wr,
	input  wire logic        sw_rd,
	output logic [31:0]      sw_rdata,
	// device register port
	output logic [31:0]      dev_addr,
	output logic [31:0]      dev_wdata,
	output logic             dev_wr,
	output logic             dev_rd,
	input  wire logic [31:0] dev_rdata,
	// memory access gate
	input  wire logic        mem_req,
	output logic             mem_grant
);

	typedef struct packed {
		dmps_state_type st;
		logic           issued;
		logic [5:0]     ddr_d;
		logic [12:0]    ddr_m;
		logic [4:0]     ddr_od;
		logic [5:0]     main_d;
		logic [12:0]    main_m;
		logic [31:0]    sec_val;
		logic           mem_init;
		logic           ddr_done;
		logic           main_done;
		logic           div2_on;
		logic           refused;
		logic [31:0]    rdata;
	} dmps_ctl_type;

	dmps_ctl_type s_r;
	dmps_ctl_type s_nxt;

	logic        bm_go;
	logic        bm_wr;
	logic [31:0] bm_addr;
	logic [31:0] bm_wdata;
	logic        bm_done;
	logic [31:0] bm_rdata;
	logic [31:0] freq_mhz;
	logic        mem_open;

	// pack a pll control word
	function automatic logic [31:0] pll_word(input logic [5:0] d, input logic [12:0] m,
			input logic [4:0] od);
		logic [31:0] w;
		w = 32'h0;
		w[PLL_D_LSB +: PLL_D_W] = d;
		w[PLL_M_LSB +: PLL_M_W] = m;
		w[PLL_OD_LSB +: PLL_OD_W] = od;
		return w;
	endfunction

	// divide-by-two merged into a read-back value
	function automatic logic [31:0] sec_merge(input logic [31:0] v);
		logic [31:0] w;
		w = v & ~SEC_OD_MASK;
		w[SEC_OD_LSB +: 4] = SEC_OD_DIV2;
		return w;
	endfunction

	// memory is open only after software reports full init
	assign mem_open  = s_r.mem_init & s_r.ddr_done;
	assign mem_grant = mem_req & mem_open;

	// device access request per state
	always_comb begin
		bm_go    = 1'b0;
		bm_wr    = 1'b1;
		bm_addr  = 32'h0;
		bm_wdata = 32'h0;
		if (!s_r.issued) begin
			case (s_r.st)
				ST_DDR_PLL: begin
					bm_go    = 1'b1;
					bm_addr  = DEV_DDR_PLL_CTL0;
					bm_wdata = pll_word(s_r.ddr_d, s_r.ddr_m, s_r.ddr_od);
				end
				ST_PHY_PLL: begin
					bm_go    = 1'b1;
					bm_addr  = DEV_PHY_PLL_CTL;
					bm_wdata[PHY_FRQ_LSB +: 2]  = PHY_FRQ_INIT;
					bm_wdata[PHY_CPCUR_LSB +: 4] = PHY_CPCUR_INIT;
				end
				ST_SEC_RD: begin
					bm_go   = 1'b1;
					bm_wr   = 1'b0;
					bm_addr = DEV_SEC_CTL;
				end
				ST_SEC_WR: begin
					bm_go    = 1'b1;
					bm_addr  = DEV_SEC_CTL;
					bm_wdata = sec_merge(s_r.sec_val);
				end
				ST_MAIN_PLL: begin
					bm_go    = 1'b1;
					bm_addr  = DEV_MAIN_PLL_CTL;
					bm_wdata = pll_word(s_r.main_d, s_r.main_m, 5'h0);
				end
				default: begin
					bm_go = 1'b0;
				end
			endcase
		end
	end

	always_comb begin
		s_nxt = s_r;
		if (bm_go) begin
			s_nxt.issued = 1'b1;
		end
		// sequencer
		if (bm_done) begin
			s_nxt.issued = 1'b0;
			case (s_r.st)
				ST_DDR_PLL: begin
					s_nxt.st = ST_PHY_PLL;
				end
				ST_PHY_PLL: begin
					s_nxt.st       = ST_IDLE;
					s_nxt.ddr_done = 1'b1;
				end
				ST_SEC_RD: begin
					s_nxt.sec_val = bm_rdata;
					s_nxt.st      = ST_SEC_WR;
				end
				ST_SEC_WR: begin
					s_nxt.div2_on = 1'b1;
					s_nxt.st      = ST_MAIN_PLL;
				end
				ST_MAIN_PLL: begin
					s_nxt.main_done = 1'b1;
					s_nxt.st        = ST_IDLE;
				end
				default: begin
					s_nxt.st = ST_IDLE;
				end
			endcase
		end
		// software writes
		if (sw_wr) begin
			case (sw_addr)
				OFF_CTRL: begin
					if (s_r.st == ST_IDLE && sw_wdata[CTRL_GO_DDR]) begin
						s_nxt.st       = ST_DDR_PLL;
						s_nxt.ddr_done = 1'b0;
					end else if (s_r.st == ST_IDLE && sw_wdata[CTRL_GO_MAIN]) begin
						s_nxt.st        = ST_SEC_RD;
						s_nxt.main_done = 1'b0;
					end
					s_nxt.mem_init = sw_wdata[CTRL_MEM_INIT];
				end
				OFF_DDR_CFG: begin
					s_nxt.ddr_d  = sw_wdata[PLL_D_LSB +: PLL_D_W];
					s_nxt.ddr_m  = sw_wdata[PLL_M_LSB +: PLL_M_W];
					s_nxt.ddr_od = sw_wdata[PLL_OD_LSB +: PLL_OD_W];
				end
				OFF_MAIN_CFG: begin
					s_nxt.main_d = sw_wdata[PLL_D_LSB +: PLL_D_W];
					s_nxt.main_m = sw_wdata[PLL_M_LSB +: PLL_M_W];
				end
				OFF_STATUS: begin
					if (sw_wdata[STAT_REFUSED]) begin
						s_nxt.refused = 1'b0;
					end
				end
				default: begin
					s_nxt.refused = s_nxt.refused;
				end
			endcase
		end
		// refused memory access, set wins over clear
		if (mem_req && !mem_open) begin
			s_nxt.refused = 1'b1;
		end
		// software reads, data one cycle later
		s_nxt.rdata = 32'h0;
		if (sw_rd) begin
			case (sw_addr)
				OFF_CTRL: begin
					s_nxt.rdata[CTRL_MEM_INIT] = s_r.mem_init;
				end
				OFF_DDR_CFG: begin
					s_nxt.rdata = pll_word(s_r.ddr_d, s_r.ddr_m, s_r.ddr_od);
				end
				OFF_MAIN_CFG: begin
					s_nxt.rdata = pll_word(s_r.main_d, s_r.main_m, 5'h0);
				end
				OFF_STATUS: begin
					s_nxt.rdata[STAT_BUSY]      = (s_r.st != ST_IDLE);
					s_nxt.rdata[STAT_DDR_DONE]  = s_r.ddr_done;
					s_nxt.rdata[STAT_MAIN_DONE] = s_r.main_done;
					s_nxt.rdata[STAT_DIV2_ON]   = s_r.div2_on;
					s_nxt.rdata[STAT_MEM_OPEN]  = mem_open;
					s_nxt.rdata[STAT_REFUSED]   = s_r.refused;
				end
				OFF_FREQ: begin
					s_nxt.rdata = freq_mhz;
				end
				default: begin
					s_nxt.rdata = 32'h0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_r        <= '0;
			s_r.st     <= ST_IDLE;
			s_r.ddr_d  <= DDR_D_RST;
			s_r.ddr_m  <= DDR_M_RST;
			s_r.ddr_od <= DDR_OD_RST;
			s_r.main_d <= MAIN_D_RST;
			s_r.main_m <= MAIN_M_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sw_rdata = s_r.rdata;

	dmps_bus_master u_bm (
		.mclk      (mclk),
		.rst       (rst),
		.go        (bm_go),
		.go_wr     (bm_wr),
		.go_addr   (bm_addr),
		.go_wdata  (bm_wdata),
		.done      (bm_done),
		.rdata     (bm_rdata),
		.dev_addr  (dev_addr),
		.dev_wdata (dev_wdata),
		.dev_wr    (dev_wr),
		.dev_rd    (dev_rd),
		.dev_rdata (dev_rdata)
	);

	dmps_freq_calc u_fc (
		.mclk     (mclk),
		.rst      (rst),
		.valid    (s_r.div2_on),
		.ref_div  (s_r.main_d),
		.mult     (s_r.main_m),
		.out_div  (SEC_OD_DIV2),
		.freq_mhz (freq_mhz)
	);

	chk_ddr_word_fields: assert property (@(posedge mclk) disable iff (rst)
		dev_wr && dev_addr == DEV_DDR_PLL_CTL0 |->
		dev_wdata == pll_word(s_r.ddr_d, s_r.ddr_m, s_r.ddr_od))
		else $error("memory pll word does not match settings");

	chk_phy_freq_sel: assert property (@(posedge mclk) disable iff (rst)
		dev_wr && dev_addr == DEV_PHY_PLL_CTL |-> dev_wdata[PHY_FRQ_LSB +: 2] == 2'h3)
		else $error("phy pll frequency select not 0x3");

	chk_phy_charge_pump: assert property (@(posedge mclk) disable iff (rst)
		dev_wr && dev_addr == DEV_PHY_PLL_CTL |-> dev_wdata[PHY_CPCUR_LSB +: 4] == 4'hF)
		else $error("phy pll charge pump not 0xF");

	chk_mem_gate_order: assert property (@(posedge mclk) disable iff (rst)
		mem_grant |-> s_r.mem_init && s_r.ddr_done && mem_req)
		else $error("memory granted before init");

	chk_mem_refused_flag: assert property (@(posedge mclk) disable iff (rst)
		mem_req && !mem_open |=> s_r.refused)
		else $error("refused access not flagged");

	chk_main_go_seq: assert property (@(posedge mclk) disable iff (rst)
		s_r.st == ST_IDLE && sw_wr && sw_addr == OFF_CTRL && !sw_wdata[CTRL_GO_DDR]
		&& sw_wdata[CTRL_GO_MAIN] |-> ##2 dev_rd && dev_addr == DEV_SEC_CTL
		##4 dev_wr && dev_addr == DEV_SEC_CTL ##4 dev_wr && dev_addr == DEV_MAIN_PLL_CTL)
		else $error("main pll sequence out of order");

	chk_main_after_div2: assert property (@(posedge mclk) disable iff (rst)
		dev_wr && dev_addr == DEV_MAIN_PLL_CTL |-> s_r.div2_on)
		else $error("main pll written before divide by two");

	chk_sec_div_field: assert property (@(posedge mclk) disable iff (rst)
		dev_wr && dev_addr == DEV_SEC_CTL |-> dev_wdata[22:19] == 4'b0001)
		else $error("secondary divider field not 0001");

	chk_sec_rmw_keep: assert property (@(posedge mclk) disable iff (rst)
		dev_wr && dev_addr == DEV_SEC_CTL |->
		(dev_wdata & ~SEC_OD_MASK) == (s_r.sec_val & ~SEC_OD_MASK))
		else $error("secondary control bits lost");

	chk_freq_after_div2: assert property (@(posedge mclk) disable iff (rst)
		!s_r.div2_on ##1 !s_r.div2_on |-> freq_mhz == 32'h0)
		else $error("frequency shown before divide by two");

endmodule // dmps_ctrl

// >>> verif/dmps_dev_model.sv
// behavioural model of the device pll registers
`timescale 1ns/1ps
module dmps_dev_model import dmps_pkg::*; #(
	parameter logic [31:0] SEC_INIT = 32'hA5A5_A5A5
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// device register port
	input  wire logic [31:0] dev_addr,
	input  wire logic [31:0] dev_wdata,
	input  wire logic        dev_wr,
	input  wire logic        dev_rd,
	output logic [31:0]      dev_rdata
);
	logic [31:0] ddr_pll_r;
	logic [31:0] phy_pll_r;
	logic [31:0] sec_r;
	logic [31:0] main_pll_r;
	logic [7:0]  ddr_wr_cnt_r;
	logic        div2;

	// divide-by-two selected in the secondary control
	assign div2 = (sec_r[SEC_OD_LSB +: 4] == SEC_OD_DIV2);

	// one reference clock drives all pll registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ddr_pll_r    <= 32'h0000_0000;
			phy_pll_r    <= 32'h0000_0000;
			sec_r        <= SEC_INIT;
			main_pll_r   <= 32'h0000_0000;
			ddr_wr_cnt_r <= 8'h00;
			dev_rdata    <= 32'h0000_0000;
		end else begin
			if (dev_wr) begin
				case (dev_addr)
					DEV_DDR_PLL_CTL0: begin
						ddr_pll_r    <= dev_wdata;
						ddr_wr_cnt_r <= ddr_wr_cnt_r + 8'h01;
					end
					DEV_PHY_PLL_CTL:  phy_pll_r  <= dev_wdata;
					DEV_SEC_CTL:      sec_r      <= dev_wdata;
					DEV_MAIN_PLL_CTL: main_pll_r <= dev_wdata;
					default: ;
				endcase
			end
			// read data stands one cycle, then toggles
			if (dev_rd && dev_addr == DEV_SEC_CTL)
				dev_rdata <= sec_r;
			else
				dev_rdata <= ~dev_rdata;
		end
	end
endmodule // dmps_dev_model

// >>> verif/tb_dmps_ctrl.sv
// self-checking testbench of the pll setup controller
`timescale 1ns/1ps
module tb_dmps_ctrl import dmps_pkg::*; ;
	logic        mclk;
	logic        rst;
	logic [4:0]  sw_addr;
	logic [31:0] sw_wdata;
	logic        sw_wr;
	logic        sw_rd;
	logic [31:0] sw_rdata;
	logic [31:0] dev_addr;
	logic [31:0] dev_wdata;
	logic        dev_wr;
	logic        dev_rd;
	logic [31:0] dev_rdata;
	logic        mem_req;
	logic        mem_grant;
	logic [31:0] rd;
	int          err_total;
	int          num_checks;

	dmps_ctrl dmps_ctrl_inst (.mclk(mclk), .rst(rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .dev_addr(dev_addr),
		.dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata),
		.mem_req(mem_req), .mem_grant(mem_grant));

	dmps_dev_model dmps_dev_model_inst (.mclk(mclk), .rst(rst), .dev_addr(dev_addr),
		.dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata));

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic sw_write(input logic [4:0] a, input logic [31:0] d);
		@(posedge mclk);
		sw_addr  <= a;
		sw_wdata <= d;
		sw_wr    <= 1'b1;
		@(posedge mclk);
		sw_wr    <= 1'b0;
	endtask

	task automatic sw_read(input logic [4:0] a, output logic [31:0] d);
		@(posedge mclk);
		sw_addr <= a;
		sw_rd   <= 1'b1;
		@(posedge mclk);
		sw_rd   <= 1'b0;
		#1 d = sw_rdata;
	endtask

	// poll a status bit under a bounded count
	task automatic wait_status(input int b);
		int n;
		n = 0;
		sw_read(OFF_STATUS, rd);
		while (rd[b] !== 1'b1 && n < 50) begin
			sw_read(OFF_STATUS, rd);
			n++;
		end
		check({31'h0, rd[b]}, 32'h0000_0001);
	endtask

	task automatic test_reset_values();
		sw_read(OFF_DDR_CFG, rd);
		check(rd, (32'h13 << PLL_OD_LSB) | (32'h27 << PLL_M_LSB));
		sw_read(OFF_FREQ, rd);
		check(rd, 32'h0000_0000);
		sw_write(5'h14, 32'hFFFF_FFFF);
		sw_read(5'h14, rd);
		check(rd, 32'h0000_0000);
		sw_read(OFF_STATUS, rd);
		check(rd, 32'h0000_0000);
	endtask

	task automatic test_gate_closed();
		@(posedge mclk);
		mem_req <= 1'b1;
		#1 check({31'h0, mem_grant}, 32'h0000_0000);
		@(posedge mclk);
		mem_req <= 1'b0;
		sw_read(OFF_STATUS, rd);
		check({31'h0, rd[STAT_REFUSED]}, 32'h0000_0001);
		sw_write(OFF_STATUS, 32'h0000_0020);
		sw_read(OFF_STATUS, rd);
		check({31'h0, rd[STAT_REFUSED]}, 32'h0000_0000);
	endtask

	task automatic test_ddr_setup();
		sw_write(OFF_CTRL, 32'h0000_0003);
		sw_read(OFF_STATUS, rd);
		check({31'h0, rd[STAT_BUSY]}, 32'h0000_0001);
		wait_status(STAT_DDR_DONE);
		check({31'h0, rd[STAT_MAIN_DONE]}, 32'h0000_0000);
		check(dmps_dev_model_inst.sec_r, 32'hA5A5_A5A5);
		check(dmps_dev_model_inst.ddr_pll_r, (32'h13 << 19) | (32'h27 << 6));
		check({30'h0, dmps_dev_model_inst.phy_pll_r[PHY_FRQ_LSB +: 2]}, 32'h3);
		check({28'h0, dmps_dev_model_inst.phy_pll_r[PHY_CPCUR_LSB +: 4]}, 32'hF);
		sw_write(OFF_CTRL, 32'h0000_0004);
		@(posedge mclk);
		mem_req <= 1'b1;
		#1 check({31'h0, mem_grant}, 32'h0000_0001);
		@(posedge mclk);
		mem_req <= 1'b0;
	endtask

	task automatic test_main_pll();
		logic [31:0] sec_exp;
		sec_exp = (32'hA5A5_A5A5 & ~32'h0078_0000) | 32'h0008_0000;
		sw_write(OFF_MAIN_CFG, (32'h3B << 6) | 32'h1);
		sw_write(OFF_CTRL, 32'h0000_0006);
		sw_write(OFF_CTRL, 32'h0000_0005);
		wait_status(STAT_MAIN_DONE);
		check({24'h0, dmps_dev_model_inst.ddr_wr_cnt_r}, 32'h0000_0001);
		check(dmps_dev_model_inst.sec_r, sec_exp);
		check({31'h0, dmps_dev_model_inst.div2}, 32'h0000_0001);
		check(dmps_dev_model_inst.main_pll_r, (32'h3B << 6) | 32'h1);
		sw_read(OFF_FREQ, rd);
		check(rd, 32'h0000_05DC);
		sw_read(OFF_STATUS, rd);
		check(rd & 32'h0000_001F, 32'h0000_001E);
		sw_read(OFF_MAIN_CFG, rd);
		check(rd, (32'h3B << 6) | 32'h1);
		sw_read(OFF_CTRL, rd);
		check(rd, 32'h0000_0004);
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		#40000;
		err_total++;
		summarize();
	end

	initial begin
		err_total  = 0;
		num_checks = 0;
		rst      = 1'b1;
		sw_addr  = 5'h00;
		sw_wdata = 32'h0000_0000;
		sw_wr    = 1'b0;
		sw_rd    = 1'b0;
		mem_req  = 1'b0;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		test_reset_values();
		test_gate_closed();
		test_ddr_setup();
		test_main_pll();
		summarize();
	end
endmodule // tb_dmps_ctrl
